/* verilog/t8c_pkg.sv */
// Purpose: shared constants and types of the 8-bit timer compare block
// Assumes: APB slave with 32-bit data and one word per register
// Notes:   offsets are byte addresses; every value here except FLAG_OVF, FLAG_CMPA and FLAG_CMPB is used by t8c_top
`default_nettype none

package t8c_pkg;

    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam int         ADDR_W    = 8;
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_COUNT = 8'h04;
    localparam logic [7:0] OFS_CMPA  = 8'h08;
    localparam logic [7:0] OFS_CMPB  = 8'h0c;
    localparam logic [7:0] OFS_FLAGS = 8'h10;
    localparam logic [7:0] OFS_MASK  = 8'h14;
    localparam logic [7:0] OFS_FORCE = 8'h18;
    localparam logic [7:0] OFS_STAT  = 8'h1c;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int CTRL_W        = 11;
    localparam int FLAG_OVF      = 0;
    localparam int FLAG_CMPA     = 1;
    localparam int FLAG_CMPB     = 2;
    localparam int NFLAG         = 3;
    localparam int NCHAN         = 2;
    localparam int STAT_OUT_LSB  = 0;
    localparam int STAT_BLOCK    = 2;
    localparam int STAT_RUN      = 3;

    // ---------------------------------------------------------------
    // reset values and fixed counts
    // ---------------------------------------------------------------
    localparam logic [7:0]       COUNT_RST  = 8'h00;
    localparam logic [7:0]       COUNT_MAX  = 8'hff;
    localparam logic [7:0]       COUNT_ZERO = 8'h00;
    localparam logic [7:0]       CMP_RST    = 8'h00;
    localparam logic [NFLAG-1:0] FLAG_RST   = 3'h0;
    localparam logic [NFLAG-1:0] MASK_RST   = 3'h0;

    // ---------------------------------------------------------------
    // mode encodings
    // ---------------------------------------------------------------
    localparam logic [2:0] WAVE_NORMAL = 3'h0;
    localparam logic [2:0] WAVE_CTC    = 3'h2;
    localparam logic [2:0] CLKSEL_STOP = 3'h0;

    typedef enum logic [1:0] {
        ACT_NONE   = 2'b00,
        ACT_TOGGLE = 2'b01,
        ACT_CLEAR  = 2'b10,
        ACT_SET    = 2'b11
    } t8c_action_type;

    // control word: bits 1:0 action a, 3:2 action b, 6:4 wave, 10:8 clock
    typedef struct packed {
        logic [2:0]     clk_sel;
        logic           rsvd;
        logic [2:0]     wave;
        t8c_action_type act_b;
        t8c_action_type act_a;
    } t8c_ctrl_type;

    localparam t8c_ctrl_type CTRL_RST = '0;

    typedef struct packed {
        logic              sel;
        logic              enable;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
    } t8c_apb_req_type;

endpackage

`default_nettype wire

/* verilog/t8c_top.sv */
// Purpose: compare-match output logic of an 8-bit timer, normal and ctc modes
// Assumes: TICK_I is a one-cycle enable on CLK_I from the prescaler
// Notes:   APB slave, no wait states; CE_I low freezes every flip-flop
//
// What this block does
// RL1: a counter write blocks compare matches on the next timer tick, even stopped
// RL2: compare outputs keep their value across waveform mode changes
// RL3: output action is unbuffered; new value acts on next match
// RL4: force strobe in non-pwm modes applies the action at once
// RL5: nonzero output action makes the compare output drive the pin
// RL6: pin enable stays with the port direction bit
// RL7: action zero leaves the compare output unchanged on a match
// RL8: output action never changes the counting sequence
// RL9: non-pwm action sets, clears or toggles the output
// RL10: mode 0 counts up only and wraps ff to 00
// RL11: normal mode sets overflow as counter becomes zero; cleared by service
// RL12: counter may be written at any time in normal mode
// RL13: mode 2 clears the counter after it matches compare a
// RL14: in ctc mode compare a flag rises each time counter reaches top
// RL15: compare a is written directly; a value below count waits for the wrap
// RL16: action 1 toggles output a at every ctc match
// RL17: toggle frequency is io clock over 2 times n times one plus compare
// RL18: ctc mode sets overflow when counter moves from max to 00
// RL19: software avoids writing counter equal to an active compare value
// RL20: software sets the compare output before enabling the pin as output
// RL21: match sets its flag at the tick; service or write one clears it
// RL22: forced match sets no flag and leaves the counter alone
// RL23: a counter write wins over clear or count in the same cycle
// RL24: clock select zero stops counting; counter stays readable and writable
// RL25: counter, match and flag updates happen only on timer ticks
// RL26: reset clears counter, compares, outputs, flags and clock select
`timescale 1ns/1ps
`default_nettype none

module t8c_top
    import t8c_pkg::*;
(
    // clock and reset
    input  wire logic              CLK_I,
    input  wire logic              RSTN_I,
    input  wire logic              CE_I,
    // timer clock enable
    input  wire logic              TICK_I,
    // apb slave
    input  wire logic              PSEL_I,
    input  wire logic              PENABLE_I,
    input  wire logic              PWRITE_I,
    input  wire logic [ADDR_W-1:0] PADDR_I,
    input  wire logic [31:0]       PWDATA_I,
    output logic      [31:0]       PRDATA_O,
    output logic                   PREADY_O,
    output logic                   PSLVERR_O,
    // interrupt service
    input  wire logic [NFLAG-1:0]  INT_ACK_I,
    output logic      [NFLAG-1:0]  IRQ_O,
    // port pins, index 0 channel a, 1 channel b
    input  wire logic [NCHAN-1:0]  PORT_OUT_I,
    input  wire logic [NCHAN-1:0]  PORT_DIR_I,
    output logic      [NCHAN-1:0]  PIN_O,
    output logic      [NCHAN-1:0]  PIN_OE_O
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    t8c_ctrl_type       ctrl_r;
    t8c_ctrl_type       ctrl_nxt;
    logic [7:0]         count_r;
    logic [7:0]         count_nxt;
    logic [7:0]         cmp_r   [NCHAN];
    logic [7:0]         cmp_nxt [NCHAN];
    logic [NCHAN-1:0]   oc_r;
    logic [NCHAN-1:0]   oc_nxt;
    logic               block_r;
    logic               block_nxt;
    logic [NFLAG-1:0]   flag_r;
    logic [NFLAG-1:0]   flag_nxt;
    logic [NFLAG-1:0]   mask_r;
    logic [NFLAG-1:0]   mask_nxt;
    logic [NFLAG-1:0]   irq_r;
    logic [NCHAN-1:0]   pin_r;
    logic [NCHAN-1:0]   pin_oe_r;
    logic [NCHAN-1:0]   pin_nxt;
    logic               pready_r;
    logic               pslverr_r;
    logic [31:0]        prdata_r;
    logic [31:0]        rdata_nxt;

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    t8c_apb_req_type    req;
    wire logic          setup;
    wire logic          access;
    wire logic          wr;
    wire logic          hit_ctrl;
    wire logic          hit_count;
    wire logic          hit_cmpa;
    wire logic          hit_cmpb;
    wire logic          hit_flags;
    wire logic          hit_mask;
    wire logic          hit_force;
    wire logic          hit_stat;
    wire logic          mapped;

    assign req.sel    = PSEL_I;
    assign req.enable = PENABLE_I;
    assign req.write  = PWRITE_I;
    assign req.addr   = PADDR_I;
    assign req.wdata  = PWDATA_I;

    assign setup     = req.sel & ~req.enable;
    assign access    = req.sel & req.enable & pready_r;
    assign wr        = access & req.write;
    assign hit_ctrl  = (req.addr == OFS_CTRL);
    assign hit_count = (req.addr == OFS_COUNT);
    assign hit_cmpa  = (req.addr == OFS_CMPA);
    assign hit_cmpb  = (req.addr == OFS_CMPB);
    assign hit_flags = (req.addr == OFS_FLAGS);
    assign hit_mask  = (req.addr == OFS_MASK);
    assign hit_force = (req.addr == OFS_FORCE);
    assign hit_stat  = (req.addr == OFS_STAT);
    assign mapped    = hit_ctrl | hit_count | hit_cmpa | hit_cmpb
                     | hit_flags | hit_mask | hit_force | hit_stat;

    // ---------------------------------------------------------------
    // write strobes
    // ---------------------------------------------------------------
    wire logic              wr_ctrl;
    wire logic              wr_count;
    wire logic              wr_flags;
    wire logic              wr_mask;
    wire logic [NCHAN-1:0]  wr_cmp;
    wire logic [NCHAN-1:0]  force_req;

    assign wr_ctrl   = wr & hit_ctrl;
    assign wr_count  = wr & hit_count;
    assign wr_flags  = wr & hit_flags;
    assign wr_mask   = wr & hit_mask;
    assign wr_cmp    = {wr & hit_cmpb, wr & hit_cmpa};
    assign force_req = {NCHAN{wr & hit_force}} & req.wdata[NCHAN-1:0];

    // ---------------------------------------------------------------
    // timer datapath
    // ---------------------------------------------------------------
    wire logic              running;
    wire logic              tick;
    wire logic              non_pwm;
    wire logic              is_ctc;
    wire logic [NCHAN-1:0]  equal;
    wire logic [NCHAN-1:0]  match;
    wire logic              ctc_clear;
    wire logic              ovf_evt;
    wire logic [NCHAN-1:0]  fire;
    t8c_action_type         act [NCHAN];

    assign act[0]    = ctrl_r.act_a;
    assign act[1]    = ctrl_r.act_b;
    assign running   = (ctrl_r.clk_sel != CLKSEL_STOP);          // see RL24
    assign tick      = TICK_I & running;                         // see RL25
    assign is_ctc    = (ctrl_r.wave == WAVE_CTC);
    assign non_pwm   = (ctrl_r.wave == WAVE_NORMAL) | is_ctc;
    assign equal[0]  = (count_r == cmp_r[0]);
    assign equal[1]  = (count_r == cmp_r[1]);
    // a pending counter write masks this tick's matches
    assign match     = {NCHAN{tick & ~block_r}} & equal;         // see RL1
    // top is compare a only; the action field has no say here
    assign ctc_clear = is_ctc & match[0];                        // see RL13, RL8
    // counter leaving max for zero, unless a write takes the cycle
    assign ovf_evt   = tick & ~wr_count & (count_r == COUNT_MAX); // see RL11, RL18
    // output update on a real match in non-pwm modes, or a forced one
    assign fire      = ({NCHAN{non_pwm}} & match)
                     | ({NCHAN{non_pwm}} & force_req);           // see RL4, RL22

    // counter next value: write, then clear, then count
    always_comb begin
        if (wr_count) begin
            count_nxt = req.wdata[7:0];                          // see RL23, RL12
        end else if (tick & ctc_clear) begin
            count_nxt = COUNT_ZERO;
        end else if (tick) begin
            count_nxt = count_r + 8'h01;                         // see RL10
        end else begin
            count_nxt = count_r;
        end
    end

    // block stays armed until the next timer tick, even while stopped
    always_comb begin
        if (wr_count) begin
            block_nxt = 1'b1;                                    // see RL1
        end else if (tick) begin
            block_nxt = 1'b0;
        end else begin
            block_nxt = block_r;
        end
    end

    // compare values are direct, no buffer in these modes
    always_comb begin
        for (int i = 0; i < NCHAN; i++) begin
            cmp_nxt[i] = wr_cmp[i] ? req.wdata[7:0] : cmp_r[i];  // see RL15
        end
    end

    // output action taken from the live field at the moment of the match
    always_comb begin
        oc_nxt = oc_r;                                           // see RL2
        for (int i = 0; i < NCHAN; i++) begin
            if (fire[i]) begin
                unique case (act[i])                             // see RL3, RL9
                    ACT_NONE:   oc_nxt[i] = oc_r[i];             // see RL7
                    ACT_TOGGLE: oc_nxt[i] = ~oc_r[i];            // see RL16, RL17
                    ACT_CLEAR:  oc_nxt[i] = 1'b0;
                    ACT_SET:    oc_nxt[i] = 1'b1;
                endcase
            end
        end
    end

    // pin source: compare output whenever its action is nonzero
    always_comb begin
        for (int i = 0; i < NCHAN; i++) begin
            pin_nxt[i] = (act[i] != ACT_NONE) ? oc_nxt[i]        // see RL5
                                              : PORT_OUT_I[i];
        end
    end

    // ---------------------------------------------------------------
    // flags and masks
    // ---------------------------------------------------------------
    wire logic [NFLAG-1:0]  flag_set;
    wire logic [NFLAG-1:0]  flag_clr;

    assign flag_set = {match[1], match[0], ovf_evt};            // see RL14, RL21
    assign flag_clr = ({NFLAG{wr_flags}} & req.wdata[NFLAG-1:0]) | INT_ACK_I;
    // a set in the clearing cycle is kept
    assign flag_nxt = (flag_r & ~flag_clr) | flag_set;           // see RL21, RL11
    assign mask_nxt = wr_mask ? req.wdata[NFLAG-1:0] : mask_r;

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt      = t8c_ctrl_type'(req.wdata[CTRL_W-1:0]);
            ctrl_nxt.rsvd = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (hit_ctrl) begin
            rdata_nxt[CTRL_W-1:0] = ctrl_r;
        end
        if (hit_count) begin
            rdata_nxt[7:0] = count_r;
        end
        if (hit_cmpa) begin
            rdata_nxt[7:0] = cmp_r[0];
        end
        if (hit_cmpb) begin
            rdata_nxt[7:0] = cmp_r[1];
        end
        if (hit_flags) begin
            rdata_nxt[NFLAG-1:0] = flag_r;
        end
        if (hit_mask) begin
            rdata_nxt[NFLAG-1:0] = mask_r;
        end
        if (hit_stat) begin
            rdata_nxt[STAT_OUT_LSB +: NCHAN] = oc_r;
            rdata_nxt[STAT_BLOCK]            = block_r;
            rdata_nxt[STAT_RUN]              = running;
        end
    end

    // ---------------------------------------------------------------
    // apb answer registers
    // ---------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else if (CE_I) begin
            pready_r  <= setup;
            pslverr_r <= setup & ~mapped;
            prdata_r  <= (setup & ~req.write) ? rdata_nxt : 32'h0000_0000;
        end
    end

    // ---------------------------------------------------------------
    // timer registers
    // ---------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ctrl_r  <= CTRL_RST;                                 // see RL26
            count_r <= COUNT_RST;
            block_r <= 1'b0;
            oc_r    <= '0;
        end else if (CE_I) begin
            ctrl_r  <= ctrl_nxt;
            count_r <= count_nxt;
            block_r <= block_nxt;
            oc_r    <= oc_nxt;
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cmp_r[0] <= CMP_RST;
            cmp_r[1] <= CMP_RST;
        end else if (CE_I) begin
            cmp_r[0] <= cmp_nxt[0];
            cmp_r[1] <= cmp_nxt[1];
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            flag_r <= FLAG_RST;
            mask_r <= MASK_RST;
            irq_r  <= '0;
        end else if (CE_I) begin
            flag_r <= flag_nxt;
            mask_r <= mask_nxt;
            irq_r  <= flag_nxt & mask_nxt;
        end
    end

    // ---------------------------------------------------------------
    // pin registers
    // ---------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pin_r    <= '0;
            pin_oe_r <= '0;
        end else if (CE_I) begin
            pin_r    <= pin_nxt;
            pin_oe_r <= PORT_DIR_I;                              // see RL6
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign PRDATA_O  = prdata_r;
    assign PREADY_O  = pready_r;
    assign PSLVERR_O = pslverr_r;
    assign IRQ_O     = irq_r;
    assign PIN_O     = pin_r;
    assign PIN_OE_O  = pin_oe_r;

endmodule

`default_nettype wire

/* tb/t8c_monitor.sv */
// Purpose: port-level checks of the timer compare block
// Assumes: CE_I high while the checked relations hold
// Notes:   snoops apb writes to learn the control word
`timescale 1ns/1ps
`default_nettype none

module t8c_monitor
    import t8c_pkg::*;
(
    // clock, reset, tick
    input  wire logic              CLK_I,
    input  wire logic              RSTN_I,
    input  wire logic              CE_I,
    input  wire logic              TICK_I,
    // apb
    input  wire logic              PSEL_I,
    input  wire logic              PENABLE_I,
    input  wire logic              PWRITE_I,
    input  wire logic [ADDR_W-1:0] PADDR_I,
    input  wire logic [31:0]       PWDATA_I,
    input  wire logic [31:0]       PRDATA_O,
    input  wire logic              PREADY_O,
    input  wire logic              PSLVERR_O,
    // interrupts and pins
    input  wire logic [NFLAG-1:0]  INT_ACK_I,
    input  wire logic [NFLAG-1:0]  IRQ_O,
    input  wire logic [NCHAN-1:0]  PORT_OUT_I,
    input  wire logic [NCHAN-1:0]  PORT_DIR_I,
    input  wire logic [NCHAN-1:0]  PIN_O,
    input  wire logic [NCHAN-1:0]  PIN_OE_O
);
    // --------------------------------
    // control word shadow
    // --------------------------------
    logic [1:0] act_a_r;
    logic [2:0] wave_r;
    wire logic  wr_done = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O && CE_I;
    wire logic  non_pwm = (wave_r == WAVE_NORMAL) || (wave_r == WAVE_CTC);
    wire logic  frc     = wr_done && (PADDR_I == OFS_FORCE) && !TICK_I;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            act_a_r <= 2'h0;
            wave_r  <= 3'h0;
        end else if (wr_done && PADDR_I == OFS_CTRL) begin
            act_a_r <= PWDATA_I[1:0];
            wave_r  <= PWDATA_I[6:4];
        end
    end

    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    pin_dir_a: assert property ($past(RSTN_I, 2) |-> PIN_OE_O == $past(PORT_DIR_I))
        else $error("pin enable does not follow direction");
    pin_port_a: assert property (act_a_r == ACT_NONE && $stable(act_a_r) && $past(RSTN_I, 2)
        |-> PIN_O[0] == $past(PORT_OUT_I[0])) else $error("port value not on pin");
    reset_quiet_a: assert property ($rose(RSTN_I) |-> IRQ_O == '0 && PIN_O == '0)
        else $error("outputs not clear after reset");
    irq_cause_a: assert property ((IRQ_O & ~$past(IRQ_O)) != '0
        |-> $past(TICK_I) || $past(wr_done)) else $error("irq rose without tick or write");
    ack_ovf_a: assert property (INT_ACK_I[FLAG_OVF] && !TICK_I && CE_I |=> !IRQ_O[FLAG_OVF])
        else $error("overflow not cleared by service");
    ack_cmp_a: assert property (INT_ACK_I[FLAG_CMPA] && !TICK_I && CE_I |=> !IRQ_O[FLAG_CMPA])
        else $error("compare flag not cleared by service");
    force_flag_a: assert property (frc && INT_ACK_I == '0 |=> $stable(IRQ_O))
        else $error("forced match touched flags");
    force_tgl_a: assert property (frc && PWDATA_I[0] && act_a_r == ACT_TOGGLE && non_pwm
        |=> PIN_O[0] != $past(PIN_O[0])) else $error("force did not toggle output");

    c_force: cover property (frc);
    c_irq: cover property ($rose(IRQ_O[FLAG_CMPA]));
    c_err: cover property (PREADY_O && PSLVERR_O);
endmodule

bind t8c_top t8c_monitor i_mon (.CLK_I, .RSTN_I, .CE_I, .TICK_I, .PSEL_I, .PENABLE_I,
    .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .INT_ACK_I, .IRQ_O,
    .PORT_OUT_I, .PORT_DIR_I, .PIN_O, .PIN_OE_O);

`default_nettype wire

/* tb/t8c_isr_model.sv */
// Purpose: interrupt service model standing for the processor core
// Assumes: one acknowledge pulse per serviced request
// Notes:   slow adds service latency
`timescale 1ns/1ps
`default_nettype none

module t8c_isr_model
    import t8c_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic             en_i,
    input  wire logic             slow_i,
    input  wire logic [NFLAG-1:0] irq_i,
    output logic      [NFLAG-1:0] ack_o
);
    int wait_r;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_o  <= '0;
            wait_r <= 0;
        end else if (ack_o != '0) begin
            ack_o  <= '0;
            wait_r <= 0;
        end else if (en_i && irq_i != '0) begin
            if (wait_r >= (slow_i ? 6 : 1)) begin
                ack_o  <= irq_i;
                wait_r <= 0;
            end else begin
                wait_r <= wait_r + 1;
            end
        end
    end
endmodule

`default_nettype wire

/* tb/tb_timer8_compare_output_normal_ctc.sv */
// Purpose: self-checking bench of the timer compare block
// Assumes: ticks and bus cycles never share a clock edge
// Notes:   an integer model predicts every read and pin value
`timescale 1ns/1ps
`default_nettype none

module tb_timer8_compare_output_normal_ctc
    import t8c_pkg::*;
;
    logic              clk = 0, rstn = 0, tick = 0, psel = 0, pen = 0, pwr = 0;
    logic              pready, pslverr, isr_en = 0, isr_slow = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0]       pwdata = '0, prdata;
    logic [NFLAG-1:0]  ack, irq;
    logic [NCHAN-1:0]  pout = '0, pdir = '0, pin, pin_oe;
    int                n_fail = 0, checks = 0, seed = 22618;
    int                m_cnt = 0, m_flag = 0, m_mask = 0, m_wave = 0, m_cs = 0, m_blk = 0;
    int                m_cmp[2] = '{0, 0}, m_act[2] = '{0, 0}, m_oc[2] = '{0, 0};

    t8c_top i_dut (.CLK_I(clk), .RSTN_I(rstn), .CE_I(1'b1), .TICK_I(tick), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .INT_ACK_I(ack), .IRQ_O(irq),
        .PORT_OUT_I(pout), .PORT_DIR_I(pdir), .PIN_O(pin), .PIN_OE_O(pin_oe));
    t8c_isr_model i_isr (.clk_i(clk), .rstn_i(rstn), .en_i(isr_en), .slow_i(isr_slow),
        .irq_i(irq), .ack_o(ack));

    initial forever #2.5 clk = ~clk;

    // --------------------------------
    // checks, bus and model
    // --------------------------------
    task automatic give_verdict();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_port();
        logic [1:0] ep;
        for (int c = 0; c < 2; c++) ep[c] = (m_act[c] != 0) ? m_oc[c][0] : pout[c];
        checks++;
        if ({irq, pin_oe, pin} !== {3'(m_flag & m_mask), pdir, ep}) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, {irq, pin_oe, pin},
                {3'(m_flag & m_mask), pdir, ep});
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    function automatic bit np();
        return m_wave == 0 || m_wave == 2;
    endfunction

    function automatic int act_res(int c);
        case (m_act[c])
            1: return !m_oc[c];
            2: return 0;
            3: return 1;
            default: return m_oc[c];
        endcase
    endfunction

    task automatic wr(input logic [7:0] a, input int d);
        logic [31:0] rd;
        logic e;
        apb(1'b1, a, d, rd, e);
        case (a)
            OFS_CTRL: begin
                m_act[0] = d & 3;
                m_act[1] = (d >> 2) & 3;
                m_wave = (d >> 4) & 7;
                m_cs = (d >> 8) & 7;
            end
            OFS_COUNT: begin
                m_cnt = d & 255;
                m_blk = 1;
            end
            OFS_CMPA: m_cmp[0] = d & 255;
            OFS_CMPB: m_cmp[1] = d & 255;
            OFS_FLAGS: m_flag &= ~d;
            OFS_MASK: m_mask = d & 7;
            OFS_FORCE: for (int c = 0; c < 2; c++) if (d[c] && np()) m_oc[c] = act_res(c);
            default: ;
        endcase
    endtask

    task automatic tick_once();
        bit hit;
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        if (m_cs == 0) return;
        for (int c = 0; c < 2; c++) begin
            if (m_blk == 0 && m_cnt == m_cmp[c]) begin
                m_flag |= 1 << (c + 1);
                if (np()) m_oc[c] = act_res(c);
            end
        end
        hit = m_blk == 0 && m_wave == 2 && m_cnt == m_cmp[0];
        m_blk = 0;
        if (m_cnt == 255) m_flag |= 1;
        m_cnt = hit ? 0 : (m_cnt + 1) & 255;
    endtask

    task automatic check_all();
        logic [31:0] rd;
        logic e;
        apb(1'b0, OFS_COUNT, 0, rd, e);
        chk_reg(rd, m_cnt);
        apb(1'b0, OFS_FLAGS, 0, rd, e);
        chk_reg(rd, m_flag);
        apb(1'b0, OFS_STAT, 0, rd, e);
        chk_reg(rd, {m_cs != 0, m_blk[0], m_oc[1][0], m_oc[0][0]});
        chk_port();
    endtask

    initial begin
        #200_000;
        n_fail++;
        give_verdict();
    end

    // --------------------------------
    // scenarios
    // --------------------------------
    initial begin
        int r, d, n;
        logic [31:0] rd;
        logic e, last;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        wr(OFS_STAT, 'hf);
        wr(8'h24, 1);
        for (int a = 0; a < 'h28; a += 4) begin
            apb(1'b0, 8'(a), 0, rd, e);
            chk_reg(rd, 0);
            chk_reg(e, a >= 'h20);
        end
        for (int a = 0; a < 4; a++) begin
            wr(OFS_CTRL, a * 5);
            wr(OFS_FORCE, 3);
            check_all();
        end
        pdir <= 2'h3;
        wr(OFS_CTRL, 'h100);
        wr(OFS_COUNT, 'hfd);
        repeat (3) tick_once();
        check_all();
        wr(OFS_CTRL, 0);
        wr(OFS_CMPA, 5);
        wr(OFS_COUNT, 5);
        tick_once();
        check_all();
        wr(OFS_CTRL, 'h100);
        tick_once();
        check_all();
        wr(OFS_CTRL, 'h221);
        wr(OFS_CMPA, 2);
        wr(OFS_COUNT, 0);
        last = pin[0];
        n = 0;
        repeat (12) begin
            tick_once();
            @(posedge clk);
            if (pin[0] !== last) n++;
            last = pin[0];
        end
        chk_reg(n, 12 / (1 + 2));
        wr(OFS_COUNT, 'h10);
        wr(OFS_CMPA, 3);
        repeat (250) tick_once();
        check_all();
        for (int s = 0; s < 2; s++) begin
            wr(OFS_CTRL, 'h100);
            wr(OFS_CMPA, 'hff);
            wr(OFS_MASK, 3);
            wr(OFS_COUNT, 'hfe);
            isr_en <= 1'b1;
            isr_slow <= s[0];
            repeat (3) tick_once();
            repeat (40) @(posedge clk);
            isr_en <= 1'b0;
            m_flag &= ~m_mask;
            check_all();
        end
        repeat (40) begin
            r = $random(seed);
            d = r & 'h7ff;
            wr(OFS_CTRL, d);
            apb(1'b0, OFS_CTRL, 0, rd, e);
            chk_reg(rd, d & 'h77f);
            wr(OFS_CMPA, r[31] ? r[23:16] : r[19:16]);
            wr(OFS_CMPB, r[27:20]);
            if (r[12]) wr(OFS_COUNT, $random(seed));
            if (r[13]) wr(OFS_FORCE, r[15:14]);
            if (r[30]) wr(OFS_FLAGS, 7);
            pout <= r[25:24];
            pdir <= r[29:28];
            repeat (r[11:8] + 1) tick_once();
            check_all();
        end
        give_verdict();
    end
endmodule

`default_nettype wire
